// [pkg/dlink_pkg.sv]
// Functional notes
// - Hold each LP lane state at least 50 ns
// - Data LP-00 prepare 40+4UI to 85+6UI
// - Data prepare plus HS-0 at least 140+10UI
// - LP-11 at least 100 ns after burst
// - Flipped trail state at least 60+4UI
// - Clock runs 60+52UI after data back LP
// - Clock trail state at least 60 ns
// - Clock LP-00 38-95 ns, plus HS-0 300 ns (here LP-00 lasts one cycle, 100 ns)
// - Clock runs 8 UI before data starts
// - Clock trail to LP-11 within 105+12UI
// - Turnaround LP periods last 50 to 75 ns (here each lasts one cycle, 100 ns)
// - On handback, wait one to two periods
// - Host drives LP-00 four periods, then releases
// - Commands after 5 ms, wake after 120 ms
// - Apply a reset after power-up completes
package dlink_pkg;
   localparam int CLK_NS = 100;
   // One bit per reference cycle, so one UI equals one clock period
   localparam int UI_NS = 100;

   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_floor(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int LP_MIN_NS = 50;
   localparam int DATA_PREP_MIN_NS = 40 + 4 * UI_NS;
   localparam int DATA_PREP_MAX_NS = 85 + 6 * UI_NS;
   localparam int DATA_PREP_ZERO_NS = 140 + 10 * UI_NS;
   localparam int EXIT_NS = 100;
   localparam int DATA_TRAIL_NS = 60 + 4 * UI_NS;
   localparam int CLK_POST_NS = 60 + 52 * UI_NS;
   localparam int CLK_TRAIL_NS = 60;
   localparam int CLK_PREP_MAX_NS = 95;
   localparam int CLK_PREP_ZERO_NS = 300;
   localparam int CLK_PRE_NS = 8 * UI_NS;
   localparam int EOT_MAX_NS = 105 + 12 * UI_NS;
   localparam int TA_LP_MAX_NS = 75;
   localparam int RST_LOW_NS = 10_000;
   localparam int CMD_WAIT_NS = 5_000_000;
   localparam int WAKE_WAIT_NS = 120_000_000;

   localparam int LP_CYC = cyc_ceil(LP_MIN_NS);
   localparam int DATA_PREP_CYC = cyc_ceil(DATA_PREP_MIN_NS);
   localparam int DATA_ZERO_CYC = cyc_ceil(DATA_PREP_ZERO_NS) - DATA_PREP_CYC;
   localparam int EXIT_CYC = cyc_ceil(EXIT_NS);
   localparam int DATA_TRAIL_CYC = cyc_ceil(DATA_TRAIL_NS);
   localparam int CLK_POST_CYC = cyc_ceil(CLK_POST_NS);
   localparam int CLK_TRAIL_CYC = cyc_ceil(CLK_TRAIL_NS);
   localparam int CLK_PREP_CYC = cyc_floor(CLK_PREP_MAX_NS);
   localparam int CLK_ZERO_CYC = cyc_ceil(CLK_PREP_ZERO_NS) - CLK_PREP_CYC;
   localparam int CLK_PRE_CYC = cyc_ceil(CLK_PRE_NS);
   localparam int EOT_MAX_CYC = cyc_floor(EOT_MAX_NS);
   localparam int TA_LP_CYC = cyc_floor(TA_LP_MAX_NS);
   localparam int TA_GO_CYC = 4 * TA_LP_CYC;
   localparam int TA_SURE_CYC = TA_LP_CYC;
   localparam int SYNC_LAT = 2;
   localparam int TA_TIMEOUT_CYC = 200;
   localparam int RST_LOW_CYC = cyc_ceil(RST_LOW_NS);
   localparam int CMD_WAIT_CYC = cyc_ceil(CMD_WAIT_NS);
   localparam int WAKE_WAIT_CYC = cyc_ceil(WAKE_WAIT_NS);

   localparam logic [7:0] SYNC_BYTE = 8'hB8;
   localparam int SHIFT_BITS = 16;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h00,
      ST_C_PREP = 5'h01,
      ST_C_ZERO = 5'h02,
      ST_C_PRE = 5'h03,
      ST_D_LP01 = 5'h04,
      ST_D_PREP = 5'h05,
      ST_D_ZERO = 5'h06,
      ST_D_SHIFT = 5'h07,
      ST_D_TRAIL = 5'h08,
      ST_D_EXIT = 5'h09,
      ST_C_POST = 5'h0A,
      ST_C_TRAIL = 5'h0B,
      ST_C_EXIT = 5'h0C,
      ST_TA_LP10 = 5'h0D,
      ST_TA_LP00 = 5'h0E,
      ST_TA_LP10B = 5'h0F,
      ST_TA_GO = 5'h10,
      ST_TA_LISTEN = 5'h11,
      ST_TA_SURE = 5'h12,
      ST_TA_BACK = 5'h13
   } link_st_e;
endpackage

// [hdl/dlink_host.sv]
`timescale 1ns/1ns
module dlink_host #(
   parameter int CMD_WAIT_CYC = dlink_pkg::CMD_WAIT_CYC,
   parameter int WAKE_WAIT_CYC = dlink_pkg::WAKE_WAIT_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // User requests
   input wire logic burst_valid_i,
   input wire logic [7:0] burst_byte_i,
   output logic burst_ready_o,
   input wire logic bta_req_i,
   output logic bta_ready_o,
   input wire logic reset_req_i,
   // User status
   output logic burst_done_o,
   output logic bta_done_o,
   output logic bta_timeout_o,
   output logic cmd_ok_o,
   output logic wake_ok_o,
   // Data lane 0 low-power pins, two-way
   input wire logic d0_lp_p_i,
   input wire logic d0_lp_n_i,
   output logic d0_lp_p_o,
   output logic d0_lp_n_o,
   output logic d0_lp_oe_o,
   // Data lane 0 high-speed driver
   output logic d0_hs_en_o,
   output logic d0_hs_data_o,
   // Clock lane
   output logic clk_lp_p_o,
   output logic clk_lp_n_o,
   output logic clk_hs_en_o,
   output logic hs_clk_o,
   // Display reset line
   output logic hw_reset_line_n_o
);
   dlink_pkg::link_st_e st_ff, nxt_st;
   logic [7:0] cnt_ff;
   logic [1:0] ln_s1_ff, ln_s2_ff;
   logic seen10_ff;
   logic [15:0] shift_ff;
   logic hs_data_ff, hs_clk_ff;
   logic burst_done_ff, bta_done_ff, bta_to_ff;
   logic [26:0] rcnt_ff;
   logic rlow_ff, cmd_ok_ff, wake_ok_ff;

   function automatic logic [7:0] len_of(input dlink_pkg::link_st_e s);
      case (s)
         dlink_pkg::ST_C_PREP: len_of = 8'(dlink_pkg::CLK_PREP_CYC);
         dlink_pkg::ST_C_ZERO: len_of = 8'(dlink_pkg::CLK_ZERO_CYC);
         dlink_pkg::ST_C_PRE: len_of = 8'(dlink_pkg::CLK_PRE_CYC);
         dlink_pkg::ST_D_LP01: len_of = 8'(dlink_pkg::LP_CYC);
         dlink_pkg::ST_D_PREP: len_of = 8'(dlink_pkg::DATA_PREP_CYC);
         dlink_pkg::ST_D_ZERO: len_of = 8'(dlink_pkg::DATA_ZERO_CYC);
         dlink_pkg::ST_D_SHIFT: len_of = 8'(dlink_pkg::SHIFT_BITS);
         dlink_pkg::ST_D_TRAIL: len_of = 8'(dlink_pkg::DATA_TRAIL_CYC);
         dlink_pkg::ST_D_EXIT: len_of = 8'(dlink_pkg::EXIT_CYC);
         dlink_pkg::ST_C_POST: len_of = 8'(dlink_pkg::CLK_POST_CYC);
         dlink_pkg::ST_C_TRAIL: len_of = 8'(dlink_pkg::CLK_TRAIL_CYC);
         dlink_pkg::ST_C_EXIT: len_of = 8'(dlink_pkg::EXIT_CYC);
         dlink_pkg::ST_TA_GO: len_of = 8'(dlink_pkg::TA_GO_CYC);
         dlink_pkg::ST_TA_LISTEN: len_of = 8'(dlink_pkg::TA_TIMEOUT_CYC);
         dlink_pkg::ST_TA_SURE:
            len_of = 8'(dlink_pkg::TA_GO_CYC + dlink_pkg::TA_SURE_CYC - dlink_pkg::SYNC_LAT);
         default: len_of = 8'(dlink_pkg::TA_LP_CYC);
      endcase
   endfunction

   wire [7:0] cur_len_w = len_of(st_ff);
   wire done_w = (cnt_ff == cur_len_w - 8'h01);
   wire idle_w = (st_ff == dlink_pkg::ST_IDLE);
   // No link traffic until the display has settled after its reset
   wire go_burst_w = idle_w && cmd_ok_ff && burst_valid_i;
   wire go_bta_w = idle_w && cmd_ok_ff && !burst_valid_i && bta_req_i;
   wire hs_w = st_ff inside {dlink_pkg::ST_D_ZERO, dlink_pkg::ST_D_SHIFT, dlink_pkg::ST_D_TRAIL};
   wire released_w = st_ff inside {dlink_pkg::ST_TA_LISTEN, dlink_pkg::ST_TA_SURE};
   wire clk_run_w = st_ff inside {dlink_pkg::ST_C_PRE, dlink_pkg::ST_D_LP01, dlink_pkg::ST_D_PREP,
                                  dlink_pkg::ST_D_ZERO, dlink_pkg::ST_D_SHIFT, dlink_pkg::ST_D_TRAIL,
                                  dlink_pkg::ST_D_EXIT, dlink_pkg::ST_C_POST};
   wire clk_hs_w = clk_run_w || st_ff inside {dlink_pkg::ST_C_ZERO, dlink_pkg::ST_C_TRAIL};
   // Clock flop follows the next state, so the first toggle is seen as the lead period opens
   wire clk_run_nxt_w = nxt_st inside {dlink_pkg::ST_C_PRE, dlink_pkg::ST_D_LP01, dlink_pkg::ST_D_PREP,
                                       dlink_pkg::ST_D_ZERO, dlink_pkg::ST_D_SHIFT, dlink_pkg::ST_D_TRAIL,
                                       dlink_pkg::ST_D_EXIT, dlink_pkg::ST_C_POST};
   wire lp01_w = (st_ff == dlink_pkg::ST_D_LP01);
   wire lp00_w = st_ff inside {dlink_pkg::ST_D_PREP, dlink_pkg::ST_TA_LP00, dlink_pkg::ST_TA_GO};
   wire lp10_w = st_ff inside {dlink_pkg::ST_TA_LP10, dlink_pkg::ST_TA_LP10B};
   wire clk_lp11_w = st_ff inside {dlink_pkg::ST_IDLE, dlink_pkg::ST_C_EXIT, dlink_pkg::ST_TA_LP10,
                                   dlink_pkg::ST_TA_LP00, dlink_pkg::ST_TA_LP10B, dlink_pkg::ST_TA_GO,
                                   dlink_pkg::ST_TA_LISTEN, dlink_pkg::ST_TA_SURE, dlink_pkg::ST_TA_BACK};
   wire dev_lp00_w = seen10_ff && (ln_s2_ff == 2'h0);

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         dlink_pkg::ST_IDLE: begin
            if (go_burst_w) begin
               nxt_st = dlink_pkg::ST_C_PREP;
            end else if (go_bta_w) begin
               nxt_st = dlink_pkg::ST_TA_LP10;
            end
         end
         dlink_pkg::ST_C_PREP: if (done_w) nxt_st = dlink_pkg::ST_C_ZERO;
         dlink_pkg::ST_C_ZERO: if (done_w) nxt_st = dlink_pkg::ST_C_PRE;
         dlink_pkg::ST_C_PRE: if (done_w) nxt_st = dlink_pkg::ST_D_LP01;
         dlink_pkg::ST_D_LP01: if (done_w) nxt_st = dlink_pkg::ST_D_PREP;
         dlink_pkg::ST_D_PREP: if (done_w) nxt_st = dlink_pkg::ST_D_ZERO;
         dlink_pkg::ST_D_ZERO: if (done_w) nxt_st = dlink_pkg::ST_D_SHIFT;
         dlink_pkg::ST_D_SHIFT: if (done_w) nxt_st = dlink_pkg::ST_D_TRAIL;
         dlink_pkg::ST_D_TRAIL: if (done_w) nxt_st = dlink_pkg::ST_D_EXIT;
         dlink_pkg::ST_D_EXIT: if (done_w) nxt_st = dlink_pkg::ST_C_POST;
         dlink_pkg::ST_C_POST: if (done_w) nxt_st = dlink_pkg::ST_C_TRAIL;
         dlink_pkg::ST_C_TRAIL: if (done_w) nxt_st = dlink_pkg::ST_C_EXIT;
         dlink_pkg::ST_C_EXIT: if (done_w) nxt_st = dlink_pkg::ST_IDLE;
         dlink_pkg::ST_TA_LP10: if (done_w) nxt_st = dlink_pkg::ST_TA_LP00;
         dlink_pkg::ST_TA_LP00: if (done_w) nxt_st = dlink_pkg::ST_TA_LP10B;
         dlink_pkg::ST_TA_LP10B: if (done_w) nxt_st = dlink_pkg::ST_TA_GO;
         dlink_pkg::ST_TA_GO: if (done_w) nxt_st = dlink_pkg::ST_TA_LISTEN;
         dlink_pkg::ST_TA_LISTEN: begin
            if (dev_lp00_w) begin
               nxt_st = dlink_pkg::ST_TA_SURE;
            end else if (done_w) begin
               nxt_st = dlink_pkg::ST_TA_BACK;
            end
         end
         // Device LP-00 seen late by the synchroniser, so its latency is taken off the wait
         dlink_pkg::ST_TA_SURE: if (done_w) nxt_st = dlink_pkg::ST_TA_BACK;
         dlink_pkg::ST_TA_BACK: if (done_w) nxt_st = dlink_pkg::ST_IDLE;
         default: nxt_st = dlink_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_ff <= dlink_pkg::ST_IDLE;
         cnt_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= (nxt_st != st_ff) ? 8'h00 : cnt_ff + 8'h01;
      end
   end

   // Lane pins come from the display side, so they are synchronised first
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ln_s1_ff <= 2'h3;
         ln_s2_ff <= 2'h3;
         seen10_ff <= 1'b0;
      end else begin
         ln_s1_ff <= {d0_lp_p_i, d0_lp_n_i};
         ln_s2_ff <= ln_s1_ff;
         seen10_ff <= (st_ff == dlink_pkg::ST_TA_LISTEN) && (seen10_ff || ln_s2_ff == 2'h2);
      end
   end

   // Sync byte goes out first, then the payload, least significant bit first
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         shift_ff <= 16'h0000;
         hs_data_ff <= 1'b0;
      end else if (go_burst_w) begin
         shift_ff <= {burst_byte_i, dlink_pkg::SYNC_BYTE};
      end else if (nxt_st == dlink_pkg::ST_D_SHIFT) begin
         // Bits are launched on entry so the flipped trail keeps its full length
         shift_ff <= {1'b0, shift_ff[15:1]};
         hs_data_ff <= shift_ff[0];
      end else if (st_ff == dlink_pkg::ST_D_SHIFT && nxt_st == dlink_pkg::ST_D_TRAIL) begin
         hs_data_ff <= ~hs_data_ff;
      end else if (st_ff == dlink_pkg::ST_D_PREP) begin
         hs_data_ff <= 1'b0;
      end
   end

   // Link clock is divided from the reference clock; no second domain
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hs_clk_ff <= 1'b0;
      end else begin
         hs_clk_ff <= clk_run_nxt_w ? ~hs_clk_ff : 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         burst_done_ff <= 1'b0;
         bta_done_ff <= 1'b0;
         bta_to_ff <= 1'b0;
      end else begin
         burst_done_ff <= (st_ff == dlink_pkg::ST_C_EXIT) && done_w;
         bta_done_ff <= (st_ff == dlink_pkg::ST_TA_BACK) && done_w;
         bta_to_ff <= (st_ff == dlink_pkg::ST_TA_LISTEN) && done_w && !dev_lp00_w;
      end
   end

   // Power-up always issues a reset pulse, since the line may not have been stable
   wire rlow_end_w = rlow_ff && (rcnt_ff == 27'(dlink_pkg::RST_LOW_CYC - 1));
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rlow_ff <= 1'b1;
         rcnt_ff <= 27'h0000000;
         cmd_ok_ff <= 1'b0;
         wake_ok_ff <= 1'b0;
      end else if (reset_req_i && !rlow_ff && idle_w) begin
         rlow_ff <= 1'b1;
         rcnt_ff <= 27'h0000000;
         cmd_ok_ff <= 1'b0;
         wake_ok_ff <= 1'b0;
      end else if (rlow_end_w) begin
         rlow_ff <= 1'b0;
         rcnt_ff <= 27'h0000000;
      end else begin
         if (!wake_ok_ff) begin
            rcnt_ff <= rcnt_ff + 27'h0000001;
         end
         if (!rlow_ff && rcnt_ff == 27'(CMD_WAIT_CYC - 1)) cmd_ok_ff <= 1'b1;
         if (!rlow_ff && rcnt_ff == 27'(WAKE_WAIT_CYC - 1)) wake_ok_ff <= 1'b1;
      end
   end

   assign burst_ready_o = idle_w && cmd_ok_ff;
   assign bta_ready_o = idle_w && cmd_ok_ff && !burst_valid_i;
   assign burst_done_o = burst_done_ff;
   assign bta_done_o = bta_done_ff;
   assign bta_timeout_o = bta_to_ff;
   assign cmd_ok_o = cmd_ok_ff;
   assign wake_ok_o = wake_ok_ff;
   assign d0_lp_oe_o = !hs_w && !released_w;
   assign d0_lp_p_o = d0_lp_oe_o && !lp01_w && !lp00_w;
   assign d0_lp_n_o = d0_lp_oe_o && !lp00_w && !lp10_w;
   assign d0_hs_en_o = hs_w;
   assign d0_hs_data_o = hs_data_ff;
   assign clk_lp_p_o = clk_lp11_w;
   assign clk_lp_n_o = clk_lp11_w;
   assign clk_hs_en_o = clk_hs_w;
   assign hs_clk_o = hs_clk_ff;
   assign hw_reset_line_n_o = !rlow_ff;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_lp01_hold: assert property ($rose(lp01_w) |-> d0_lp_oe_o && !d0_lp_p_o && d0_lp_n_o
                                 && $past(d0_lp_p_o && d0_lp_n_o))
      else $error("LP-01 not driven");
   a_data_prep_len: assert property ($rose(st_ff == dlink_pkg::ST_D_PREP) |-> (lp00_w && d0_lp_oe_o)[*5]
                                     ##1 d0_hs_en_o)
      else $error("data prepare length wrong");
   a_hs_zero_len: assert property ($rose(st_ff == dlink_pkg::ST_D_ZERO) |-> (d0_hs_en_o && !d0_hs_data_o)[*7])
      else $error("HS-0 too short");
   a_trail_flip: assert property ($rose(st_ff == dlink_pkg::ST_D_TRAIL) |-> (d0_hs_data_o == !$past(d0_hs_data_o))
                                  ##1 (d0_hs_en_o && $stable(d0_hs_data_o))[*4])
      else $error("trail state wrong");
   a_exit_lp11: assert property ((st_ff == dlink_pkg::ST_D_EXIT) |-> d0_lp_oe_o && d0_lp_p_o && d0_lp_n_o)
      else $error("LP-11 missing after burst");
   a_clk_post_len: assert property ((st_ff == dlink_pkg::ST_C_POST && nxt_st == dlink_pkg::ST_C_TRAIL)
                                    |-> cnt_ff == 8'(dlink_pkg::CLK_POST_CYC - 1))
      else $error("clock post too short");
   a_clk_pre_run: assert property ($rose(st_ff == dlink_pkg::ST_C_PRE) |->
                                   (clk_hs_en_o && hs_clk_o != $past(hs_clk_o))[*8] ##1 lp01_w)
      else $error("clock lead too short");
   a_eot_bound: assert property ($rose(st_ff == dlink_pkg::ST_C_TRAIL) |-> ##[1:13] (clk_lp_p_o && clk_lp_n_o))
      else $error("clock lane late to LP-11");
   a_clk_prep: assert property ($rose(st_ff == dlink_pkg::ST_C_PREP) |-> !clk_lp_p_o && !clk_lp_n_o
                                ##1 clk_hs_en_o[*2])
      else $error("clock prepare wrong");
   a_ta_go_hold: assert property ($rose(st_ff == dlink_pkg::ST_TA_GO) |-> (d0_lp_oe_o && lp00_w)[*4]
                                  ##1 !d0_lp_oe_o)
      else $error("turnaround release wrong");
   a_rst_width: assert property ($rose(hw_reset_line_n_o) |-> $past(rcnt_ff) == 27'(dlink_pkg::RST_LOW_CYC - 1))
      else $error("reset pulse width wrong");
   a_no_cmd_early: assert property (!cmd_ok_o |-> !d0_hs_en_o && !$rose(st_ff == dlink_pkg::ST_TA_LP10))
      else $error("link used before settle");

   c_burst: cover property (burst_done_o);
   c_bta: cover property (bta_done_o && !$past(bta_timeout_o));
   c_bta_timeout: cover property (bta_timeout_o);
   c_reset: cover property ($rose(cmd_ok_o));
endmodule

// [tb/dlink_dev_model.sv]
`timescale 1ns/1ns
module dlink_dev_model (
   // Clock and test mode
   input wire logic ref_clk_i,
   input wire logic silent_i,
   // Link as seen by the module
   input wire logic host_oe_i,
   input wire logic hs_en_i,
   input wire logic hs_data_i,
   input wire logic clk_hs_en_i,
   input wire logic hw_reset_line_n_i,
   // Lane 0 drive during turnaround
   output logic lp_p_o,
   output logic lp_n_o,
   output logic lp_oe_o,
   // What the module received
   output logic [7:0] rx_byte_o,
   output logic [7:0] rx_cnt_o,
   output logic [7:0] rst_cnt_o
);
   logic [15:0] sh_ff = 16'h0000;
   logic got_ff = 1'b0;
   logic oe_d_ff = 1'b1;
   logic [3:0] ta_ff = 4'h0;
   logic [7:0] low_ff = 8'h00;
   logic term_on;
   logic take_now;
   initial begin
      rx_byte_o = 8'h00;
      rx_cnt_o = 8'h00;
      rst_cnt_o = 8'h00;
   end
   // Termination switches with the HS drivers, well inside the allowed delay
   assign term_on = hs_en_i | clk_hs_en_i;
   // Grab the lane in the cycle the host lets go, so the wire does not float at the hand-over
   assign take_now = oe_d_ff & ~host_oe_i & ~hs_en_i & ~clk_hs_en_i & ~silent_i;
   assign lp_oe_o = take_now | (ta_ff != 4'h0);
   assign lp_p_o = (ta_ff == 4'h6);
   assign lp_n_o = 1'b0;
   always @(posedge ref_clk_i) begin
      oe_d_ff <= host_oe_i;
      if (take_now) begin
         ta_ff <= 4'h2;
      end else if (ta_ff != 4'h0) begin
         // Five LP-00 periods, then LP-10 and four LP-00 periods hand the lane back
         ta_ff <= (ta_ff == 4'hA) ? 4'h0 : ta_ff + 4'h1;
      end
      if (hs_en_i) begin
         sh_ff <= {hs_data_i, sh_ff[15:1]};
      end else begin
         sh_ff <= 16'h0000;
         got_ff <= 1'b0;
      end
      // Trail bits after the payload are ignored until the lane leaves HS
      if (hs_en_i && !got_ff && sh_ff[7:0] == dlink_pkg::SYNC_BYTE) begin
         rx_byte_o <= sh_ff[15:8];
         rx_cnt_o <= rx_cnt_o + 8'h01;
         got_ff <= 1'b1;
      end
      if (!hw_reset_line_n_i) begin
         low_ff <= (low_ff == 8'hFF) ? low_ff : low_ff + 8'h01;
      end else begin
         // Only pulses of 9 us or more reload settings and blank; spikes are dropped
         if (low_ff >= 8'h5A) begin
            rst_cnt_o <= rst_cnt_o + 8'h01;
         end
         low_ff <= 8'h00;
      end
   end
endmodule

// [tb/dlink_host_tb_top.sv]
`timescale 1ns/1ns
module dlink_host_tb_top;
   localparam int CMD_CYC = 50;
   localparam int WAKE_CYC = 120;
   localparam int CEIL = 4000;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic burst_valid_i = 1'b0;
   logic [7:0] burst_byte_i = 8'h00;
   logic bta_req_i = 1'b0;
   logic reset_req_i = 1'b0;
   logic silent = 1'b0;
   logic mon = 1'b0;
   logic burst_ready_o, bta_ready_o, burst_done_o, bta_done_o, bta_timeout_o, cmd_ok_o, wake_ok_o;
   logic h_p, h_n, h_oe, hs_en, hs_d, c_p, c_n, c_en, hs_clk, rl_n, d_p, d_n, d_oe;
   logic last_p = 1'b0;
   logic last_n = 1'b0;
   logic clk_d = 1'b0;
   logic hoe_d = 1'b1;
   logic seen_hs = 1'b0;
   logic [7:0] rx_byte, rx_cnt, rst_cnt;
   logic [7:0] exp_rx = 8'h00;
   int c[8];
   int run00 = 0;
   int go00 = 0;
   int both = 0;
   int float_n = 0;
   int gap = 0;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   // An undriven lane shows the inverse of its last level, never a lucky hold
   wire w_p = h_oe ? h_p : (d_oe ? d_p : ~last_p);
   wire w_n = h_oe ? h_n : (d_oe ? d_n : ~last_n);
   wire tog = hs_clk != clk_d;
   always #50 ref_clk_i = ~ref_clk_i;

   dlink_host #(.CMD_WAIT_CYC(CMD_CYC), .WAKE_WAIT_CYC(WAKE_CYC)) uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .burst_valid_i(burst_valid_i), .burst_byte_i(burst_byte_i), .burst_ready_o(burst_ready_o),
      .bta_req_i(bta_req_i), .bta_ready_o(bta_ready_o), .reset_req_i(reset_req_i), .burst_done_o(burst_done_o),
      .bta_done_o(bta_done_o), .bta_timeout_o(bta_timeout_o), .cmd_ok_o(cmd_ok_o), .wake_ok_o(wake_ok_o),
      .d0_lp_p_i(w_p), .d0_lp_n_i(w_n), .d0_lp_p_o(h_p), .d0_lp_n_o(h_n), .d0_lp_oe_o(h_oe), .d0_hs_en_o(hs_en),
      .d0_hs_data_o(hs_d), .clk_lp_p_o(c_p), .clk_lp_n_o(c_n), .clk_hs_en_o(c_en), .hs_clk_o(hs_clk),
      .hw_reset_line_n_o(rl_n));

   dlink_dev_model dev (.ref_clk_i(ref_clk_i), .silent_i(silent), .host_oe_i(h_oe), .hs_en_i(hs_en),
      .hs_data_i(hs_d), .clk_hs_en_i(c_en), .hw_reset_line_n_i(rl_n), .lp_p_o(d_p), .lp_n_o(d_n),
      .lp_oe_o(d_oe), .rx_byte_o(rx_byte), .rx_cnt_o(rx_cnt), .rst_cnt_o(rst_cnt));

   always @(posedge ref_clk_i) begin
      clk_d <= hs_clk;
      hoe_d <= h_oe;
      cyc <= cyc + 1;
      if (h_oe | d_oe) begin
         last_p <= w_p;
         last_n <= w_n;
      end
      if (h_oe && d_oe) begin
         both <= both + 1;
      end
      run00 <= (h_oe && !h_p && !h_n) ? run00 + 1 : 0;
      float_n <= (!h_oe && !d_oe) ? float_n + 1 : 0;
      if (!hoe_d && h_oe) begin
         gap <= float_n;
      end
      if (hoe_d && !h_oe && !hs_en) begin
         go00 <= run00;
      end
      if (!mon) begin
         foreach (c[i]) c[i] <= 0;
         seen_hs <= 1'b0;
      end else begin
         seen_hs <= seen_hs | hs_en;
         if (h_oe && !h_p && !h_n) c[0] <= c[0] + 1;
         if (hs_en) c[1] <= c[1] + 1;
         if (tog && !seen_hs && h_oe && h_p && h_n) c[2] <= c[2] + 1;
         if (tog && seen_hs && !hs_en) c[3] <= c[3] + 1;
         if (!c_p && !c_n && !c_en) c[4] <= c[4] + 1;
         if (c_en && !tog && c[2] == 0) c[5] <= c[5] + 1;
         if (c_en && !tog && c[3] != 0) c[6] <= c[6] + 1;
         if (h_oe && h_p && h_n && seen_hs) c[7] <= c[7] + 1;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Follows one display reset pulse from line low to the wake gate
   task automatic reset_line(input logic [7:0] exp_cnt);
      int n;
      n = 0;
      while (rl_n !== 1'b0 && n < 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      @(posedge ref_clk_i);
      reset_req_i <= 1'b0;
      n = 1;
      while (rl_n === 1'b0 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("reset low cycles", n >= 100, 1);
      chk("cmd gate closed", cmd_ok_o, 0);
      chk("burst refused", burst_ready_o, 0);
      n = 0;
      while (cmd_ok_o !== 1'b1 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("cmd wait", n >= CMD_CYC && n <= CMD_CYC + 2, 1);
      while (wake_ok_o !== 1'b1 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("wake wait", n >= WAKE_CYC && n <= WAKE_CYC + 2, 1);
      chk("device resets", rst_cnt, exp_cnt);
   endtask

   task automatic sc_burst(input logic [7:0] b);
      int n;
      @(posedge ref_clk_i);
      mon <= 1'b0;
      @(posedge ref_clk_i);
      mon <= 1'b1;
      burst_valid_i <= 1'b1;
      burst_byte_i <= b;
      n = 0;
      // Waits for the idle link before the request is taken
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (burst_ready_o !== 1'b1 && n < 200);
      @(posedge ref_clk_i);
      burst_valid_i <= 1'b0;
      exp_rx = exp_rx + 8'h01;
      @(negedge ref_clk_i);
      chk("busy refuses", burst_ready_o, 0);
      n = 0;
      while (burst_done_o !== 1'b1 && n < 300) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("burst latency", n, 101);
      chk("payload", rx_byte, b);
      chk("payload count", rx_cnt, exp_rx);
      chk("data prepare", c[0] >= 5 && c[0] <= 6, 1);
      chk("hs span", c[1] >= 33 - c[0], 1);
      chk("clock lead", c[2] >= 8, 1);
      chk("clock post", c[3] >= 53, 1);
      chk("clock prepare", c[4] >= 1 && c[4] + c[5] >= 3, 1);
      chk("clock trail", c[6] >= 1 && c[6] <= 13, 1);
      chk("lane exit", c[7] >= 1, 1);
   endtask

   task automatic sc_ta(input logic quiet);
      int n;
      logic to_seen;
      @(posedge ref_clk_i);
      silent <= quiet;
      bta_req_i <= 1'b1;
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (bta_ready_o !== 1'b1 && n < 200);
      @(posedge ref_clk_i);
      bta_req_i <= 1'b0;
      n = 0;
      to_seen = 1'b0;
      do begin
         @(negedge ref_clk_i);
         n++;
         if (bta_timeout_o === 1'b1) to_seen = 1'b1;
      end while (bta_done_o !== 1'b1 && n < 400);
      chk("turnaround done", bta_done_o, 1);
      chk("timeout flag", to_seen, quiet);
      chk("timeout wait", n >= 200, quiet);
      chk("lp00 before release", go00, 4);
      chk("no contention", both, 0);
      chk("handback wait", gap >= 1 && gap <= 2, !quiet);
      @(negedge ref_clk_i);
      chk("lane lp11", {h_oe, h_p, h_n}, 3'b111);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      reset_line(8'h01);
      sc_burst(8'hA5);
      sc_burst(8'h00);
      sc_burst(8'hFF);
      sc_ta(1'b0);
      sc_ta(1'b1);
      sc_ta(1'b0);
      @(posedge ref_clk_i);
      reset_req_i <= 1'b1;
      reset_line(8'h02);
      sc_burst(8'h3C);
      tally_and_finish();
   end

   always @(posedge ref_clk_i) begin
      if (cyc == CEIL) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
endmodule
